// ---- hdl/bdm_pkg.sv ----
/*
 * Constants for the banked data address map: address widths, bank layout,
 * access-map split, special-register area and the bank pointer location.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bdm_pkg;
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 8;
	localparam int          BANK_W          = 4;
	localparam int          OFFS_W          = 8;
	localparam int          BANK_COUNT      = 16;
	localparam int          BANK_SIZE       = 256;
	localparam logic [3:0]  BANK_ZERO       = 4'h0;
	localparam logic [3:0]  BANK_TOP        = 4'hF;
	localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
	localparam logic [11:0] SFR_BASE        = 12'hF80;
	localparam logic [11:0] SFR_LAST        = 12'hFFF;
	localparam logic [11:0] BANK_PTR_ADDR   = 12'hFE0;
	localparam logic [11:0] PCL_ADDR        = 12'hFF9;
	localparam logic [3:0]  BANK_PTR_RESET  = 4'h0;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [1:0]  Q1              = 2'h0;
	localparam logic [1:0]  Q2              = 2'h1;
	localparam logic [1:0]  Q3              = 2'h2;
	localparam logic [1:0]  Q4              = 2'h3;
	localparam logic [15:0] INDIRECT_LOW    = 16'h0000;
	localparam logic [11:0] IND_PORT0_BASE  = 12'hFEB;
	localparam logic [11:0] IND_PORT1_BASE  = 12'hFE3;
	localparam logic [11:0] IND_PORT2_BASE  = 12'hFDB;
	localparam logic [11:0] IND_PORT_SPAN   = 12'h005;
endpackage : bdm_pkg

// ---- hdl/bdm_addr_if.sv ----
/*
 * Interface carrying an address request from the map to the address former.
 * Assumes one clock domain; all signals combinational within a cycle.
 */
`timescale 1ns/100ps
interface bdm_addr_if;
	logic        access_sel;
	logic        full_move;
	logic        ext_mode;
	logic [3:0]  bank;
	logic [7:0]  offset;
	logic [11:0] full_addr;
	logic [11:0] addr;
	logic        alt_map;

	modport former (
		input  access_sel,
		input  full_move,
		input  ext_mode,
		input  bank,
		input  offset,
		input  full_addr,
		output addr,
		output alt_map
	);
	modport user (
		output access_sel,
		output full_move,
		output ext_mode,
		output bank,
		output offset,
		output full_addr,
		input  addr,
		input  alt_map
	);
endinterface : bdm_addr_if

// ---- hdl/bdm_addr_former.sv ----
/*
 * Forms the 12-bit data address from bank pointer, operand and access bit.
 * Assumes the caller drives the request fields every cycle.
 */
`timescale 1ns/100ps
module bdm_addr_former (
	bdm_addr_if.former ai
);
	always_comb begin
		ai.alt_map = 1'b0;
		if (ai.full_move) begin
			ai.addr = ai.full_addr;
		end else if (ai.access_sel) begin
			ai.addr = {ai.bank, ai.offset};
		end else if (ai.offset < bdm_pkg::ACCESS_SPLIT) begin
			ai.addr = {bdm_pkg::BANK_ZERO, ai.offset};
			ai.alt_map = ai.ext_mode;
		end else begin
			ai.addr = {bdm_pkg::BANK_TOP, ai.offset};
		end
	end
endmodule : bdm_addr_former

// ---- hdl/bdm_map.sv ----
/*
 * Banked data memory map: bank pointer, address forming, general RAM,
 * special-register storage with zero reads for unused slots, indirect
 * port redirection and quarter-cycle read/write timing.
 * Assumes the core supplies a quarter-cycle phase and decoded controls.
 */
`timescale 1ns/100ps
module bdm_map #(
	parameter int BANKS_IMPL = 16
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  q_phase,
	input  wire logic        ext_set_enable,
	input  wire logic        access_sel,
	input  wire logic        full_move,
	input  wire logic [7:0]  offset,
	input  wire logic [11:0] full_src_addr,
	input  wire logic [11:0] full_dst_addr,
	input  wire logic        rd_en,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_data,
	input  wire logic        move_literal_to_bank,
	input  wire logic [7:0]  literal,
	input  wire logic [11:0] ind_ptr0,
	input  wire logic [11:0] ind_ptr1,
	input  wire logic [11:0] ind_ptr2,
	input  wire logic [7:0]  alt_rd_data,
	input  wire logic [255:0] sfr_impl_mask,
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	output logic [11:0]      cur_addr,
	output logic             alt_map_req,
	output logic             pcl_write,
	output logic [3:0]       bank_pointer_bits
);
	initial begin
		if (BANKS_IMPL < 1 || BANKS_IMPL > bdm_pkg::BANK_COUNT)
			$error("BANKS_IMPL out of range");
	end

	//------------------------------------------------------------
	// Address forming
	//------------------------------------------------------------
	bdm_addr_if ai ();
	bdm_addr_former u_former (
		.ai (ai)
	);

	logic       is_write_phase;
	logic       is_read_phase;
	assign is_read_phase  = (q_phase == bdm_pkg::Q2);
	assign is_write_phase = (q_phase == bdm_pkg::Q4);

	logic [3:0] bank_reg;
	logic [3:0] bank_next;

	assign ai.access_sel = access_sel;
	assign ai.full_move  = full_move;
	assign ai.ext_mode   = ext_set_enable;
	assign ai.bank       = bank_reg;
	assign ai.offset     = offset;
	// Source address in read phase, destination otherwise
	assign ai.full_addr  = is_read_phase ? full_src_addr : full_dst_addr;

	//------------------------------------------------------------
	// Indirect port redirection
	//------------------------------------------------------------
	logic [11:0] eff_addr;
	logic        ind_hit;
	always_comb begin
		ind_hit  = 1'b1;
		eff_addr = ai.addr;
		if (ai.addr >= bdm_pkg::IND_PORT0_BASE &&
		    ai.addr <  bdm_pkg::IND_PORT0_BASE + bdm_pkg::IND_PORT_SPAN) begin
			eff_addr = ind_ptr0;
		end else if (ai.addr >= bdm_pkg::IND_PORT1_BASE &&
		    ai.addr <  bdm_pkg::IND_PORT1_BASE + bdm_pkg::IND_PORT_SPAN) begin
			eff_addr = ind_ptr1;
		end else if (ai.addr >= bdm_pkg::IND_PORT2_BASE &&
		    ai.addr <  bdm_pkg::IND_PORT2_BASE + bdm_pkg::IND_PORT_SPAN) begin
			eff_addr = ind_ptr2;
		end else begin
			ind_hit = 1'b0;
		end
	end

	//------------------------------------------------------------
	// Decode of the effective address
	//------------------------------------------------------------
	logic       in_sfr;
	logic       bank_ok;
	logic       sfr_used;
	logic [7:0] sfr_idx;
	logic       is_bank_ptr;
	assign in_sfr   = (eff_addr >= bdm_pkg::SFR_BASE);
	assign sfr_idx  = eff_addr[7:0];
	assign sfr_used = sfr_impl_mask[sfr_idx];
	assign is_bank_ptr = (eff_addr == bdm_pkg::BANK_PTR_ADDR);
	assign bank_ok  = (32'(eff_addr[11:8]) < BANKS_IMPL) ||
	                  (eff_addr[11:8] == bdm_pkg::BANK_TOP);

	//------------------------------------------------------------
	// Storage: general RAM and special registers, no reset
	//------------------------------------------------------------
	logic [7:0] ram_mem [0:bdm_pkg::BANK_COUNT*bdm_pkg::BANK_SIZE-1];
	logic       mem_we;
	logic       alt_map_q;
	assign alt_map_q = ai.alt_map;
	assign mem_we = wr_en && is_write_phase && bank_ok && !is_bank_ptr &&
	                !(ind_hit && eff_addr == ai.addr) &&
	                (!in_sfr || sfr_used) && !alt_map_q;

	always_ff @(posedge clock) begin
		if (mem_we)
			ram_mem[eff_addr] <= wr_data;
	end

	//------------------------------------------------------------
	// Bank pointer
	//------------------------------------------------------------
	always_comb begin
		bank_next = bank_reg;
		if (move_literal_to_bank && is_write_phase)
			bank_next = literal[3:0];
		else if (wr_en && is_write_phase && is_bank_ptr)
			bank_next = wr_data[3:0];
	end

	//------------------------------------------------------------
	// Read path and output registers
	//------------------------------------------------------------
	logic [7:0]  rd_data_reg;
	logic [7:0]  rd_data_next;
	logic        rd_valid_reg;
	logic        rd_valid_next;
	logic [11:0] cur_addr_reg;
	logic [11:0] cur_addr_next;
	logic        alt_reg;
	logic        alt_next;
	logic        pcl_reg;
	logic        pcl_next;

	always_comb begin
		rd_data_next  = rd_data_reg;
		rd_valid_next = 1'b0;
		cur_addr_next = cur_addr_reg;
		alt_next      = ai.alt_map;
		pcl_next      = wr_en && is_write_phase && !ai.alt_map &&
		                (eff_addr == bdm_pkg::PCL_ADDR);
		if (rd_en && is_read_phase) begin
			rd_valid_next = 1'b1;
			cur_addr_next = eff_addr;
			if (ai.alt_map)
				rd_data_next = alt_rd_data;
			else if (is_bank_ptr)
				rd_data_next = {4'h0, bank_reg};
			else if (!bank_ok)
				rd_data_next = bdm_pkg::ZERO_BYTE;
			else if (in_sfr && !sfr_used)
				rd_data_next = bdm_pkg::ZERO_BYTE;
			else
				rd_data_next = ram_mem[eff_addr];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bank_reg     <= bdm_pkg::BANK_PTR_RESET;
			rd_data_reg  <= bdm_pkg::ZERO_BYTE;
			rd_valid_reg <= 1'b0;
			cur_addr_reg <= 12'h000;
			alt_reg      <= 1'b0;
			pcl_reg      <= 1'b0;
		end else begin
			bank_reg     <= bank_next;
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			cur_addr_reg <= cur_addr_next;
			alt_reg      <= alt_next;
			pcl_reg      <= pcl_next;
		end
	end

	assign rd_data           = rd_data_reg;
	assign rd_valid          = rd_valid_reg;
	assign cur_addr          = cur_addr_reg;
	assign alt_map_req       = alt_reg;
	assign pcl_write         = pcl_reg;
	assign bank_pointer_bits = bank_reg;
endmodule : bdm_map

// ---- sim/bdm_map_monitor.sv ----
/* Checker for bdm_map: read timing, address forming, bank loads.
   Assumes it is bound onto bdm_map; one clock, synchronous reset. */
`timescale 1ns/100ps
module bdm_map_monitor (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [1:0]  q_phase,
	input wire logic        ext_set_enable,
	input wire logic        access_sel,
	input wire logic        full_move,
	input wire logic [7:0]  offset,
	input wire logic [11:0] full_src_addr,
	input wire logic        rd_en,
	input wire logic        wr_en,
	input wire logic        move_literal_to_bank,
	input wire logic [7:0]  literal,
	input wire logic        rd_valid,
	input wire logic [11:0] cur_addr,
	input wire logic        pcl_write,
	input wire logic [3:0]  bank_pointer_bits
);
	wire rq = rd_en && q_phase == bdm_pkg::Q2;
	wire acc = rq && !access_sel && !full_move && !ext_set_enable;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_ld;
		move_literal_to_bank && q_phase == bdm_pkg::Q4;
	endsequence
	property p_v; rq |=> rd_valid; endproperty
	a_v: assert property (p_v) else $error("read not answered");
	property p_nv; !rq |=> !rd_valid; endproperty
	a_nv: assert property (p_nv) else $error("stray rd_valid");
	property p_ld; s_ld |=> {4'h0, bank_pointer_bits} == ($past(literal) & 8'h0F); endproperty
	a_ld: assert property (p_ld) else $error("bank load wrong");
	property p_lo; acc && offset < 8'h80 |=> cur_addr == {4'h0, $past(offset)}; endproperty
	a_lo: assert property (p_lo) else $error("low access address");
	property p_hi; acc && offset >= 8'h80 |=> cur_addr == {4'hF, $past(offset)}; endproperty
	a_hi: assert property (p_hi) else $error("high access address");
	property p_bk;
		rq && access_sel && !full_move |=> cur_addr == {$past(bank_pointer_bits), $past(offset)};
	endproperty
	a_bk: assert property (p_bk) else $error("banked address");
	property p_fm; rq && full_move |=> cur_addr == $past(full_src_addr); endproperty
	a_fm: assert property (p_fm) else $error("full move address");
	property p_pc;
		wr_en && q_phase == bdm_pkg::Q4 && access_sel && !full_move
			&& bank_pointer_bits == 4'hF && offset == 8'hF9 |=> pcl_write;
	endproperty
	a_pc: assert property (p_pc) else $error("counter low write missed");
endmodule : bdm_map_monitor
bind bdm_map bdm_map_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .q_phase(q_phase),
	.ext_set_enable(ext_set_enable), .access_sel(access_sel), .full_move(full_move),
	.offset(offset), .full_src_addr(full_src_addr), .rd_en(rd_en), .wr_en(wr_en),
	.move_literal_to_bank(move_literal_to_bank), .literal(literal), .rd_valid(rd_valid),
	.cur_addr(cur_addr), .pcl_write(pcl_write), .bank_pointer_bits(bank_pointer_bits));

// ---- sim/bdm_core_model.sv ----
/* Stand-in for the core pipeline: steps the quarter-cycle phase.
   Assumes the map's clock and synchronous reset. */
`timescale 1ns/100ps
module bdm_core_model (
	input  wire logic  clock,
	input  wire logic  sys_rst,
	output logic [1:0] q_phase
);
	logic [1:0] phase_reg;
	assign q_phase = phase_reg;
	// Four quarters make one instruction cycle
	always_ff @(posedge clock) begin
		phase_reg <= sys_rst ? bdm_pkg::Q1 : phase_reg + 2'h1;
	end
endmodule : bdm_core_model

// ---- sim/bdm_map_bench.sv ----
/* Self-checking bench for bdm_map, driven in quarter-phase steps.
   Assumes bdm_core_model supplies the phase. */
`timescale 1ns/100ps
module bdm_map_bench;
	logic         clock, sys_rst, ext_set_enable, access_sel, full_move, rd_en, wr_en;
	logic         move_literal_to_bank, rd_valid, alt_map_req, pcl_write;
	logic [1:0]   q_phase;
	logic [3:0]   bank_pointer_bits;
	logic [7:0]   offset, wr_data, literal, alt_rd_data, rd_data;
	logic [11:0]  full_src_addr, full_dst_addr, ind_ptr0, ind_ptr1, ind_ptr2, cur_addr;
	logic [255:0] sfr_impl_mask;
	int           miscompares, n_tests;
	always #12.5 clock = ~clock;
	bdm_core_model u_core (.clock(clock), .sys_rst(sys_rst), .q_phase(q_phase));
	bdm_map #(.BANKS_IMPL(8)) uut (.clock(clock), .sys_rst(sys_rst), .q_phase(q_phase),
		.ext_set_enable(ext_set_enable), .access_sel(access_sel), .full_move(full_move),
		.offset(offset), .full_src_addr(full_src_addr), .full_dst_addr(full_dst_addr),
		.rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .literal(literal),
		.move_literal_to_bank(move_literal_to_bank), .ind_ptr0(ind_ptr0),
		.ind_ptr1(ind_ptr1), .ind_ptr2(ind_ptr2), .alt_rd_data(alt_rd_data),
		.sfr_impl_mask(sfr_impl_mask), .rd_data(rd_data), .rd_valid(rd_valid),
		.cur_addr(cur_addr), .alt_map_req(alt_map_req), .pcl_write(pcl_write),
		.bank_pointer_bits(bank_pointer_bits));
	task automatic final_report;
		if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic cmp(input string nm, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	// Returns at the edge that ends the wanted quarter
	task automatic sync(input logic [1:0] ph);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			if (q_phase === ph) return;
		end
		miscompares++;
		final_report();
	endtask : sync
	task automatic op(input logic w, input logic a, input logic [7:0] off, input logic [7:0] d);
		sync(w ? bdm_pkg::Q3 : bdm_pkg::Q1);
		rd_en <= !w;
		wr_en <= w;
		access_sel <= a;
		offset <= off;
		wr_data <= d;
		@(posedge clock);
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		#1;
	endtask : op
	task automatic rchk(input logic a, input logic [7:0] off, input logic [7:0] exp);
		op(1'b0, a, off, 8'h00);
		cmp("rd_valid", 12'h001, 12'(rd_valid));
		cmp("rd_data", 12'(exp), 12'(rd_data));
	endtask : rchk
	task automatic mlb(input logic [7:0] lit);
		sync(bdm_pkg::Q3);
		move_literal_to_bank <= 1'b1;
		literal <= lit;
		@(posedge clock);
		move_literal_to_bank <= 1'b0;
		#1;
		cmp("bank", 12'(lit[3:0]), 12'(bank_pointer_bits));
	endtask : mlb
	initial begin
		{clock, sys_rst, ext_set_enable, access_sel, full_move} = 5'h08;
		{rd_en, wr_en, move_literal_to_bank, offset, wr_data, literal} = 27'h0;
		{full_src_addr, full_dst_addr, ind_ptr0, ind_ptr1, ind_ptr2} = 60'h0;
		alt_rd_data = 8'h6E;
		sfr_impl_mask = ~(256'h1 << 8'h9C);
		{miscompares, n_tests} = 64'h0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		mlb(8'hA5);
		rchk(1'b0, 8'hE0, 8'h05);
		op(1'b1, 1'b0, 8'hE0, 8'hFF);
		rchk(1'b0, 8'hE0, 8'h0F);
		op(1'b1, 1'b1, 8'hF9, 8'h00);
		cmp("pcl_write", 12'h001, 12'(pcl_write));
		op(1'b1, 1'b0, 8'h10, 8'h3C);
		rchk(1'b0, 8'h10, 8'h3C);
		cmp("cur_addr", 12'h010, cur_addr);
		mlb(8'h00);
		rchk(1'b1, 8'h10, 8'h3C);
		op(1'b1, 1'b0, 8'h80, 8'h12);
		rchk(1'b0, 8'h80, 8'h12);
		op(1'b1, 1'b0, 8'h9C, 8'h55);
		rchk(1'b0, 8'h9C, 8'h00);
		mlb(8'h03);
		op(1'b1, 1'b1, 8'h22, 8'h5A);
		full_move = 1'b1;
		full_src_addr = 12'h322;
		rchk(1'b1, 8'h00, 8'h5A);
		full_move = 1'b0;
		mlb(8'h09);
		op(1'b1, 1'b1, 8'h44, 8'h77);
		rchk(1'b1, 8'h44, 8'h00);
		ind_ptr0 = 12'h040;
		op(1'b1, 1'b0, 8'hEF, 8'h99);
		rchk(1'b0, 8'h40, 8'h99);
		ext_set_enable = 1'b1;
		rchk(1'b0, 8'h20, 8'h6E);
		cmp("alt_map_req", 12'h001, 12'(alt_map_req));
		ext_set_enable = 1'b0;
		sys_rst = 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		rchk(1'b0, 8'h10, 8'h3C);
		cmp("bank", 12'(bdm_pkg::BANK_PTR_RESET), 12'(bank_pointer_bits));
		final_report();
	end
endmodule : bdm_map_bench
